// [rtl/ecpr_pkg.sv]
/*
 * Package for the parallel-port register and shared FIFO block: offsets,
 * mode codes, field positions, reset values and timing counts.
 * Assumes a 250 MHz system clock.
 */
package ecpr_pkg;
    // Register offsets (all 11 address bits are decoded)
    localparam logic [10:0] OFF_DATA   = 11'h000;
    localparam logic [10:0] OFF_STATUS = 11'h001;
    localparam logic [10:0] OFF_CTRL   = 11'h002;
    localparam logic [10:0] OFF_FIFO   = 11'h400;
    localparam logic [10:0] OFF_CFGB   = 11'h401;
    localparam logic [10:0] OFF_ECTL   = 11'h402;
    localparam logic [10:0] OFF_EIDX   = 11'h403;
    localparam logic [10:0] OFF_EDAT   = 11'h404;
    localparam logic [10:0] OFF_EAUX   = 11'h405;
    // Second-level indices
    localparam logic [2:0] IDX_CTL0  = 3'h0;
    localparam logic [2:0] IDX_CTL2  = 3'h2;
    localparam logic [2:0] IDX_CTL4  = 3'h4;
    localparam logic [2:0] IDX_SETUP = 3'h5;
    // Mode field codes
    localparam logic [2:0] MODE_STD  = 3'h0;
    localparam logic [2:0] MODE_BIDI = 3'h1;
    localparam logic [2:0] MODE_CFIF = 3'h2;
    localparam logic [2:0] MODE_ECP  = 3'h3;
    localparam logic [2:0] MODE_EPP  = 3'h4;
    localparam logic [2:0] MODE_TEST = 3'h6;
    localparam logic [2:0] MODE_CFG  = 3'h7;
    // Extended control fields
    localparam int ECTL_EMPTY = 0;
    localparam int ECTL_FULL  = 1;
    localparam int ECTL_SERV  = 2;
    localparam int ECTL_DMAEN = 3;
    localparam int ECTL_MODE  = 5;
    localparam int CTRL_DIR   = 5;
    localparam int SETUP_DEMAND = 6;
    localparam logic [7:0] ECTL_RST  = 8'h15;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] CFGA_HI   = 8'h10;
    localparam logic [7:0] CFGA_LO   = 8'h04;
    localparam logic [7:0] UNDEF_RD  = 8'h00;
    // Timing
    localparam int CLK_MHZ       = 250;
    localparam int EPP_TMO_US    = 10;
    localparam int EPP_TMO_CYC   = EPP_TMO_US * CLK_MHZ;
    localparam int SETTLE_NS     = 40;
    localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int DMA_BURST_MAX = 32;
    localparam int DEMAND_COUNT  = 4;
    localparam int FIFO_DEPTH    = 16;

    // FIFO entry: byte plus command tag
    typedef struct packed {
        logic       cmd;
        logic [7:0] data;
    } ecpr_entry_t;

    // Host bus request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } ecpr_bus_t;
endpackage

// [rtl/ecpr_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and a synchronous clear from the owner.
 */
`timescale 1ns/1ps
module ecpr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,      // System clock
    input  wire logic             rst_n,    // Reset, active low
    input  wire logic             clr,      // Flush contents
    input  wire logic             in_valid, // Push request
    output logic                  in_ready, // Room available
    input  wire logic [WIDTH-1:0] in_data,  // Push data
    output logic                  out_valid,// Data available
    input  wire logic             out_ready,// Pop request
    output logic [WIDTH-1:0]      out_data, // Head data
    output logic [$clog2(DEPTH):0] count    // Fill level
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("ecpr_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign count     = wp_q - rp_q;
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else if (clr)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wp_q[AW-1:0]] <= in_data;
    end
endmodule

// [rtl/ecpr_port.sv]
/*
 * Register set, mode decode and shared FIFO access of an extended
 * parallel port. Host PIO and DMA reach byte registers; the peripheral
 * supplies status lines. Bus strobes are one-cycle pulses synchronous
 * to clk_sys; the peripheral-side ECP cycle engine drains/fills the FIFO
 * through the link_* ports.
 */
// Functional notes
// - Four FIFO ports share one FIFO, selected by offset and mode.
// - With DMA enabled, requests fill forward or empty backward.
// - DMA request never held beyond 32 consecutive DMA cycles.
// - Terminal count during own DMA cycle stops requests.
// - Demand option waits until DMA need has held for four cycles.
// - Full-FIFO writes dropped, empty reads undefined, flags untouched.
// - Access to unavailable register is a no-op.
// - ECP enabled replaces legacy data register only; status, control remain.
// - Handshake sampling waits for data to settle after each link pop.
// - Index/data registers reach second-level controls when enabled.
// - Modes 000/001 data read returns pin levels, or pd_out while driving.
// - Mode 011 forward command-port writes push tagged command.
// - Status bit 0: 1 outside EPP, timeout set, read clears.
// - Status returns fixed ones, line levels, inverted busy.
// - Control read returns stored bits 5-0; bits 7,6 read 1.
// - Strobe is inverse of control bit 0 in every mode.
// - Auto-linefeed inverse of bit 1, also ECP hardware in 011.
// - Reset line follows bit 2; select-in is inverse of bit 3.
// - Control bit 4 masks char-received interrupt, never floats it.
// - Modes 000/010 force forward; data driven only forward.
// - Mode 010 data-port writes push data; bits 7,6 read 1.
// - FIFO is 16 bytes with one tag per byte.
// - Mode field bits 7-5 select operating mode.
`timescale 1ns/1ps
module ecpr_port
    import ecpr_pkg::*;
#(
    parameter int DEPTH   = ecpr_pkg::FIFO_DEPTH,
    parameter int TMO_CYC = ecpr_pkg::EPP_TMO_CYC
) (
    input  wire logic              clk_sys,     // 250 MHz clock
    input  wire logic              nrst,        // Async reset, active low
    input  wire ecpr_pkg::ecpr_bus_t bus,       // PIO request
    output logic [7:0]             rdata,       // Read data
    input  wire logic              cfg_ext_en,  // Config bit 4
    input  wire logic              base_sel,    // Base addr bit 2 or 10
    output logic                   dma_req,     // DMA request
    input  wire logic              dma_ack,     // DMA cycle strobe
    input  wire logic              dma_tc,      // Terminal count
    input  wire logic [7:0]        dma_wdata,   // DMA write byte
    output logic [7:0]             dma_rdata,   // DMA read byte
    input  wire logic [7:0]        pd_in,       // Data pin levels
    output logic [7:0]             pd_out,      // Data pin drive
    output logic                   pd_oe,       // Data pin enable
    input  wire logic              err_n,       // Fault line
    input  wire logic              online_select, // Select line
    input  wire logic              media_out,   // Paper end line
    input  wire logic              ack_n,       // Char-received line
    input  wire logic              busy,        // Busy line
    input  wire logic              epp_timeout, // EPP cycle timed out
    input  wire logic              ecp_afd,     // ECP hardware linefeed
    output logic                   host_data_strobe_n, // Strobe
    output logic                   auto_linefeed_n,    // Linefeed
    output logic                   init_n,      // Printer reset
    output logic                   select_in_line_n,   // Select-in
    output logic                   irq,         // Interrupt request
    output logic                   link_valid,  // FIFO head to link
    input  wire logic              link_ready,  // Link took head
    output ecpr_pkg::ecpr_entry_t  link_data,   // Head entry
    input  wire logic              link_wvalid, // Link byte in
    output logic                   link_wready, // FIFO has room
    input  wire logic [7:0]        link_wdata,  // Byte from link
    output logic                   hs_sample    // Handshake sample ok
);
    initial
    begin
        if (DEPTH != FIFO_DEPTH)
            $error("ecpr_port: FIFO depth must be 16");
        if (TMO_CYC < 1)
            $error("ecpr_port: timeout must be positive");
    end

    // Reset release
    logic rs1_q, rst_n;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    logic [7:0] data_q, ctrl_q, ectl_q, eidx_q, eaux_q;
    logic [7:0] ctl0_q, ctl2_q, ctl4_q, setup_q;
    logic       tmo_q;
    logic [5:0] burst_q;
    logic [2:0] pend_q;
    logic       tc_stop_q;
    logic [2:0] mode_prev_q;
    logic [$clog2(SETTLE_CYC+1):0] settle_q;

    wire [2:0] mode = ectl_q[7:5];
    wire       fwd  = (mode == MODE_STD) || (mode == MODE_CFIF)
                      || !ctrl_q[CTRL_DIR];
    wire       epp  = (mode == MODE_EPP);
    wire       ext_ok = cfg_ext_en && base_sel;

    function automatic logic hit(input logic [10:0] a,
                                 input logic [10:0] off);
        hit = (a == off);
    endfunction

    wire rd = bus.rd;
    wire wr = bus.wr;
    wire [10:0] a = bus.addr;

    // FIFO access decode
    wire wr_cmd  = wr && hit(a, OFF_DATA) && mode == MODE_ECP
                   && fwd;
    wire wr_dat  = wr && hit(a, OFF_FIFO)
                   && (mode == MODE_CFIF
                   || (mode == MODE_ECP && fwd)
                   || mode == MODE_TEST);
    wire rd_fifo = rd && hit(a, OFF_FIFO)
                   && ((mode == MODE_ECP && !fwd)
                   || mode == MODE_TEST);
    wire fifo_mode = mode == MODE_CFIF || mode == MODE_ECP
                     || mode == MODE_TEST;

    // DMA transfer in progress
    wire dma_wr = dma_ack && fwd && fifo_mode;
    wire dma_rd = dma_ack && !fwd && fifo_mode;

    ecpr_entry_t f_in, f_out;
    logic f_in_ready, f_out_valid;
    logic [$clog2(DEPTH):0] f_count;
    wire link_push = link_wvalid && !fwd && mode == MODE_ECP;
    wire f_push  = wr_cmd || wr_dat || dma_wr || link_push;
    wire host_pop = rd_fifo || dma_rd;
    wire link_pop = link_ready && link_valid;
    wire f_pop   = host_pop || link_pop;
    wire f_clr   = (mode_prev_q == MODE_CFIF || mode_prev_q == MODE_ECP)
                   && !(mode == MODE_CFIF || mode == MODE_ECP);

    always_comb
    begin
        f_in.cmd  = wr_cmd;
        f_in.data = dma_wr ? dma_wdata :
                    link_push ? link_wdata : bus.wdata;
    end

    // Full writes and empty reads are dropped by the FIFO itself
    ecpr_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
        .clk      (clk_sys),
        .rst_n    (rst_n),
        .clr      (f_clr),
        .in_valid (f_push),
        .in_ready (f_in_ready),
        .in_data  (f_in),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data (f_out),
        .count    (f_count)
    );

    assign link_valid  = f_out_valid && fwd && fifo_mode
                         && mode != MODE_TEST;
    assign link_data   = f_out;
    assign link_wready = f_in_ready && !fwd && mode == MODE_ECP;

    // DMA request control
    wire dma_en   = ectl_q[ECTL_DMAEN] && !ectl_q[ECTL_SERV];
    wire dma_need = fifo_mode && (fwd ? f_in_ready : f_out_valid);
    wire demand   = setup_q[SETUP_DEMAND];
    wire pend_ok  = !demand || pend_q == 3'(DEMAND_COUNT);
    assign dma_req = dma_en && dma_need && pend_ok && !tc_stop_q
                     && burst_q < 6'(DMA_BURST_MAX);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            burst_q   <= '0;
            pend_q    <= '0;
            tc_stop_q <= 1'b0;
        end
        else
        begin
            if (dma_ack && dma_req)
                burst_q <= burst_q + 6'd1;
            else if (!dma_req)
                burst_q <= '0;
            if (!dma_en)
                tc_stop_q <= 1'b0;
            else if (dma_ack && dma_tc)
                tc_stop_q <= 1'b1;
            if (!dma_need || !demand)
                pend_q <= '0;
            else if (pend_q != 3'(DEMAND_COUNT))
                pend_q <= pend_q + 3'd1;
        end
    end
    assign dma_rdata = f_out.data;

    // Register writes
    wire w_data = wr && hit(a, OFF_DATA)
                  && (mode == MODE_STD || mode == MODE_BIDI);
    wire w_ctrl = wr && hit(a, OFF_CTRL);
    wire w_ectl = wr && hit(a, OFF_ECTL);
    wire w_eidx = wr && hit(a, OFF_EIDX) && ext_ok;
    wire w_edat = wr && hit(a, OFF_EDAT) && ext_ok;
    wire w_eaux = wr && hit(a, OFF_EAUX);
    wire r_stat = rd && hit(a, OFF_STATUS);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_q  <= '0;
            ctrl_q  <= CTRL_RST;
            ectl_q  <= ECTL_RST;
            eidx_q  <= '0;
            eaux_q  <= '0;
            ctl0_q  <= '0;
            ctl2_q  <= '0;
            ctl4_q  <= '0;
            setup_q <= SETUP_RST;
        end
        else
        begin
            if (w_data)
                data_q <= bus.wdata;
            if (w_ctrl)
                ctrl_q <= bus.wdata;
            if (w_ectl)
                ectl_q <= {bus.wdata[7:2], 2'b00};
            if (w_eidx)
                eidx_q <= bus.wdata;
            if (w_eaux)
                eaux_q <= bus.wdata;
            if (w_edat && eidx_q[2:0] == IDX_CTL0)
                ctl0_q <= bus.wdata;
            if (w_edat && eidx_q[2:0] == IDX_CTL2)
                ctl2_q <= bus.wdata;
            if (w_edat && eidx_q[2:0] == IDX_CTL4)
                ctl4_q <= bus.wdata;
            if (w_edat && eidx_q[2:0] == IDX_SETUP)
                setup_q <= bus.wdata;
        end
    end

    // EPP timeout flag; a timeout in the read cycle wins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmo_q       <= 1'b1;
            mode_prev_q <= MODE_STD;
        end
        else
        begin
            mode_prev_q <= mode;
            if (epp && mode_prev_q != MODE_EPP)
                tmo_q <= 1'b0;
            else if (epp && epp_timeout)
                tmo_q <= 1'b1;
            else if (r_stat)
                tmo_q <= 1'b0;
        end
    end

    // Settling delay after each link pop before handshake sampling
    wire pd_change = f_pop && link_pop;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            settle_q <= '0;
        else if (pd_change)
            settle_q <= ($clog2(SETTLE_CYC+1)+1)'(SETTLE_CYC);
        else if (settle_q != '0)
            settle_q <= settle_q - 1'b1;
    end
    assign hs_sample = (settle_q == '0);

    // Read mux
    wire [7:0] stat = {~busy, ack_n, media_out, online_select, err_n,
                       2'b11, epp ? tmo_q : 1'b1};
    wire [7:0] ext_rd = eidx_q[2:0] == IDX_CTL0 ? ctl0_q :
                        eidx_q[2:0] == IDX_CTL2 ? ctl2_q :
                        eidx_q[2:0] == IDX_CTL4 ? ctl4_q :
                        eidx_q[2:0] == IDX_SETUP ? setup_q : UNDEF_RD;
    logic [7:0] rmux;
    always_comb
    begin
        rmux = UNDEF_RD;
        if (hit(a, OFF_DATA) && (mode == MODE_STD || mode == MODE_BIDI))
            rmux = pd_oe ? pd_out : pd_in;
        else if (hit(a, OFF_STATUS))
            rmux = stat;
        else if (hit(a, OFF_CTRL))
            rmux = {2'b11, ctrl_q[5:0]};
        else if (hit(a, OFF_FIFO) && rd_fifo)
            rmux = f_out_valid ? f_out.data : UNDEF_RD;
        else if (hit(a, OFF_FIFO) && mode == MODE_CFG)
            rmux = CFGA_HI | {4'h0, setup_q[7], 3'h0} | CFGA_LO;
        else if (hit(a, OFF_CFGB) && mode == MODE_CFG)
            rmux = {1'b0, irq, setup_q[5:3], 1'b0, setup_q[1:0]};
        else if (hit(a, OFF_ECTL))
            rmux = {ectl_q[7:2], !f_in_ready, !f_out_valid};
        else if (hit(a, OFF_EIDX) && ext_ok)
            rmux = eidx_q;
        else if (hit(a, OFF_EDAT) && ext_ok)
            rmux = ext_rd;
        else if (hit(a, OFF_EAUX))
            rmux = eaux_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata  <= '0;
            pd_out <= '0;
            pd_oe  <= 1'b0;
            irq    <= 1'b0;
            host_data_strobe_n <= 1'b1;
            auto_linefeed_n    <= 1'b1;
            init_n             <= 1'b0;
            select_in_line_n   <= 1'b1;
        end
        else
        begin
            if (rd)
                rdata <= rmux;
            pd_out <= fifo_mode && mode != MODE_TEST ? f_out.data : data_q;
            pd_oe  <= fwd;
            irq    <= ctrl_q[4] && !ack_n;
            host_data_strobe_n <= !ctrl_q[0];
            auto_linefeed_n <= !(ctrl_q[1]
                || (mode == MODE_ECP && ecp_afd));
            init_n           <= ctrl_q[2];
            select_in_line_n <= !ctrl_q[3];
        end
    end
endmodule

// [verification/ecpr_port_sva.sv]
/*
 * Checker for ecpr_port: DMA limits, read data, status map, link flow.
 * Bound to every ecpr_port instance; sees that module's ports only.
 */
`timescale 1ns/1ps
module ecpr_port_sva
    import ecpr_pkg::*;
#(
    parameter int DEPTH   = 16,
    parameter int TMO_CYC = 2500
) (
    input wire logic                 clk_sys,       // Clock
    input wire logic                 nrst,          // Reset, active low
    input wire ecpr_pkg::ecpr_bus_t  bus,           // PIO request
    input wire logic [7:0]           rdata,         // Read data
    input wire logic                 dma_req,       // DMA request
    input wire logic                 dma_ack,       // DMA strobe
    input wire logic                 dma_tc,        // Terminal count
    input wire logic                 err_n,         // Fault line
    input wire logic                 online_select, // Select line
    input wire logic                 media_out,     // Paper end line
    input wire logic                 ack_n,         // Char received
    input wire logic                 busy,          // Busy line
    input wire logic                 irq,           // Interrupt
    input wire logic                 link_valid,    // Head valid
    input wire logic                 link_ready,    // Head taken
    input wire ecpr_pkg::ecpr_entry_t link_data     // Head entry
);
    logic [5:0] run_q;
    logic [5:0] run_d;

    // Back-to-back serviced DMA cycles
    assign run_d = (dma_req && dma_ack) ? run_q + 6'h01 : 6'h00;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            run_q <= 6'h00;
        else
            run_q <= run_d;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_burst_cap: assert property ((dma_req && dma_ack) |-> run_q < 6'd32)
        else $error("dma request held past burst limit");
    a_tc_stop: assert property ((dma_req && dma_ack && dma_tc) |=> !dma_req [*4])
        else $error("dma request after terminal count");
    a_irq_cause: assert property (irq |-> !$past(ack_n))
        else $error("irq without char received");
    a_rdata_holds: assert property (!$past(bus.rd) |-> $stable(rdata))
        else $error("read data changed without read");
    a_status_map: assert property (bus.rd && bus.addr == OFF_STATUS |=>
        rdata[7:1] == {!$past(busy), $past(ack_n), $past(media_out),
                       $past(online_select), $past(err_n), 2'b11})
        else $error("status read mismatch");
    a_ctrl_ones: assert property (bus.rd && bus.addr == OFF_CTRL |=> rdata[7:6] == 2'b11)
        else $error("control top bits not ones");
    a_undef_zero: assert property (bus.rd && bus.addr[10] && bus.addr[2:1] == 2'b11
        |=> rdata == UNDEF_RD)
        else $error("unmapped read not zero");
    a_head_holds: assert property (link_valid && !link_ready && !bus.wr && !bus.rd
        |=> link_valid && $stable(link_data))
        else $error("fifo head dropped while stalled");
endmodule

bind ecpr_port ecpr_port_sva #(.DEPTH(DEPTH), .TMO_CYC(TMO_CYC)) ecpr_port_sva_i (
    .clk_sys, .nrst, .bus, .rdata, .dma_req, .dma_ack, .dma_tc, .err_n,
    .online_select, .media_out, .ack_n, .busy, .irq, .link_valid,
    .link_ready, .link_data);

// [verification/ecpr_periph_model.sv]
/*
 * Peripheral and link partner: drives data pins when the port releases
 * them, sinks forward FIFO entries, feeds three backward bytes.
 * Assumes push_en is raised only in backward ECP mode.
 */
`timescale 1ns/1ps
module ecpr_periph_model
    import ecpr_pkg::*;
#(
    parameter logic [7:0] REV_BYTE = 8'hC3
) (
    input wire logic        clk_sys,     // Clock
    input wire logic [7:0]  pd_out,      // Port drive
    input wire logic        pd_oe,       // Port drives pins
    output logic [7:0]      pd_in,       // Pin levels
    input wire logic        stall,       // Hold off forward sink
    input wire logic        push_en,     // Allow backward bytes
    input wire logic        link_valid,  // Head valid
    output logic            link_ready,  // Head taken
    input wire ecpr_entry_t link_data,   // Head entry
    output logic            link_wvalid, // Byte offered
    input wire logic        link_wready, // Byte taken
    output logic [7:0]      link_wdata   // Byte value
);
    ecpr_entry_t got [64];
    int          gcnt = 0;
    logic [7:0]  wcnt = 8'h00;

    assign pd_in       = pd_oe ? pd_out : REV_BYTE;
    assign link_ready  = !stall;
    // Offer held until taken
    assign link_wvalid = push_en && (wcnt < 8'h03);
    assign link_wdata  = 8'h80 + wcnt;

    always @(posedge clk_sys)
    begin
        if (link_valid && link_ready)
        begin
            got[gcnt % 64] <= link_data;
            gcnt <= gcnt + 1;
        end
        if (link_wvalid && link_wready)
            wcnt <= wcnt + 8'h01;
    end
endmodule

// [verification/tb_top.sv]
/*
 * Testbench for ecpr_port: register sequences with expected values.
 * Assumes the checker is bound and the partner model sits on the link.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            $display("wrong value %s exp %h got %h", n, e, g); \
            num_errors++; \
        end \
    end
module tb_top;
    import ecpr_pkg::*;
    logic clk_sys, nrst, cfg_ext_en, base_sel, dma_req, dma_ack, dma_tc;
    logic err_n, online_select, media_out, ack_n, busy, irq, pd_oe;
    logic stb_n, afd_n, init_n, sel_n, link_valid, link_ready, link_wvalid;
    logic link_wready, stall, push_en, hs_sample;
    logic [7:0] rdata, dma_wdata, pd_in, pd_out, link_wdata;
    ecpr_bus_t   bus;
    ecpr_entry_t link_data;
    int num_errors = 0;
    int num_checks = 0;
    int n, g0;

    ecpr_port #(.DEPTH(16), .TMO_CYC(100)) ecpr_port_i (
        .clk_sys, .nrst, .bus, .rdata, .cfg_ext_en, .base_sel, .dma_req,
        .dma_ack, .dma_tc, .dma_wdata, .dma_rdata(), .pd_in, .pd_out,
        .pd_oe, .err_n, .online_select, .media_out, .ack_n, .busy,
        .epp_timeout(1'b0), .ecp_afd(stall), .host_data_strobe_n(stb_n),
        .auto_linefeed_n(afd_n), .init_n, .select_in_line_n(sel_n), .irq,
        .link_valid, .link_ready, .link_data, .link_wvalid, .link_wready,
        .link_wdata, .hs_sample);
    ecpr_periph_model ecpr_periph_model_i (
        .clk_sys, .pd_out, .pd_oe, .pd_in, .stall, .push_en, .link_valid,
        .link_ready, .link_data, .link_wvalid, .link_wready, .link_wdata);

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys);
        bus.wr = 1'b0;
    endtask
    task automatic rd(input logic [10:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hFF);
        @(negedge clk_sys);
        bus.rd = 1'b1;
        bus.addr = a;
        @(negedge clk_sys);
        bus.rd = 1'b0;
        @(negedge clk_sys);
        `CHK("rdata", e & m, rdata & m)
    endtask
    task automatic summarize();
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial
    begin
        #40000;
        num_errors++;
        summarize();
    end

    initial
    begin
        nrst = 1'b0;
        bus = '0;
        {cfg_ext_en, base_sel, dma_ack, dma_tc, stall, push_en} = '0;
        dma_wdata = 8'h00;
        {busy, ack_n, media_out, online_select, err_n} = 5'b01001;
        repeat (5) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("pins", 4'b1101, {stb_n, afd_n, init_n, sel_n})
        rd(OFF_ECTL, ECTL_RST);
        wr(OFF_CTRL, 8'h0F);
        repeat (2) @(negedge clk_sys);
        `CHK("pins", 4'b0010, {stb_n, afd_n, init_n, sel_n})
        rd(OFF_CTRL, 8'hCF, 8'hDF);
        wr(OFF_CTRL, 8'h1C);
        ack_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK("irq", 1'b1, irq)
        wr(OFF_CTRL, 8'h0C);
        repeat (2) @(negedge clk_sys);
        `CHK("irq", 1'b0, irq)
        for (n = 0; n < 2; n++)
        begin
            {busy, ack_n, media_out, online_select, err_n} = n ? 5'b10010 : 5'b01101;
            wr(OFF_STATUS, 8'h00);
            rd(OFF_STATUS, {~busy, ack_n, media_out, online_select, err_n, 3'h7});
        end
        wr(OFF_ECTL, 8'h14);
        wr(OFF_DATA, 8'h5A);
        wr(OFF_CTRL, 8'h2C);
        rd(OFF_DATA, 8'h5A);
        `CHK("pd_oe", 1'b1, pd_oe)
        wr(OFF_ECTL, 8'h34);
        rd(OFF_DATA, 8'hC3);
        `CHK("pd_oe", 1'b0, pd_oe)
        wr(OFF_CTRL, 8'h0C);
        wr(OFF_ECTL, 8'h14);
        wr(OFF_ECTL, 8'hD4);
        for (n = 0; n < 17; n++)
            wr(OFF_FIFO, 8'h20 + n[7:0]);
        rd(OFF_ECTL, 8'hD6);
        for (n = 0; n < 16; n++)
            rd(OFF_FIFO, 8'h20 + n[7:0]);
        rd(OFF_FIFO, UNDEF_RD);
        rd(11'h406, UNDEF_RD);
        rd(OFF_ECTL, 8'hD5);
        wr(OFF_ECTL, 8'h14);
        stall = 1'b1;
        wr(OFF_ECTL, 8'h74);
        wr(OFF_DATA, 8'hA5);
        wr(OFF_FIFO, 8'h3C);
        rd(OFF_DATA, UNDEF_RD);
        `CHK("head", 9'h1A5, link_data)
        `CHK("afd", 1'b0, afd_n)
        g0 = ecpr_periph_model_i.gcnt;
        stall = 1'b0;
        repeat (6) @(negedge clk_sys);
        `CHK("link", 9'h03C, ecpr_periph_model_i.got[g0 + 1])
        `CHK("hs", 1'b0, hs_sample)
        wr(OFF_ECTL, 8'h34);
        wr(OFF_CTRL, 8'h2C);
        wr(OFF_ECTL, 8'h74);
        push_en = 1'b1;
        repeat (8) @(negedge clk_sys);
        for (n = 0; n < 3; n++)
            rd(OFF_FIFO, 8'h80 + n[7:0]);
        wr(OFF_DATA, 8'h55);
        rd(OFF_ECTL, 8'h75);
        push_en = 1'b0;
        wr(OFF_ECTL, 8'h34);
        wr(OFF_CTRL, 8'h0C);
        wr(OFF_ECTL, 8'h14);
        {cfg_ext_en, base_sel} = 2'b11;
        wr(OFF_EIDX, 8'h02);
        wr(OFF_EDAT, 8'h5A);
        cfg_ext_en = 1'b0;
        wr(OFF_EDAT, 8'h11);
        cfg_ext_en = 1'b1;
        rd(OFF_EDAT, 8'h5A);
        wr(OFF_ECTL, 8'h4C);
        @(negedge clk_sys);
        `CHK("dma_req", 1'b0, dma_req)
        wr(OFF_ECTL, 8'h48);
        @(negedge clk_sys);
        g0 = ecpr_periph_model_i.gcnt;
        n = 0;
        while (dma_req === 1'b1 && n < 40)
        begin
            dma_ack = 1'b1;
            dma_wdata = n[7:0];
            @(negedge clk_sys);
            n++;
        end
        dma_ack = 1'b0;
        `CHK("bursts", 32, n)
        repeat (20) @(negedge clk_sys);
        for (n = 0; n < 32; n++)
            `CHK("link", {1'b0, n[7:0]}, ecpr_periph_model_i.got[(g0 + n) % 64])
        n = 0;
        while (dma_req !== 1'b1 && n < 10)
        begin
            @(negedge clk_sys);
            n++;
        end
        {dma_ack, dma_tc} = 2'b11;
        @(negedge clk_sys);
        {dma_ack, dma_tc} = 2'b00;
        repeat (6) @(negedge clk_sys);
        `CHK("dma_req", 1'b0, dma_req)
        summarize();
    end
endmodule
